// >>> core/tsdc_top.sv
// Transfer sequencer: neutral pause, elevator delay, panel buttons.
// Assumes pins are asynchronous and transfer requests come from the
// same-clock source-delay logic once its own delays have run out.
//
// The register offsets and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
`include "tsdc_defines.svh"
module tsdc_top #(
  parameter int unsigned TICK_CYCLES = `TSDC_TICK_CYC
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire tsdc_pkg::tsdc_pin_t pins,
  input wire logic xfer_req,
  input wire logic rexfer_req,
  input wire logic conn_fault,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic cmd_open,
  output logic cmd_norm,
  output logic cmd_emer,
  output logic elev_out,
  output logic ovr_pulse,
  output logic test_active,
  output logic test_led,
  output logic ex_sched,
  output logic ex_active,
  output logic conn_flash
);
  import tsdc_pkg::*;

  logic [10:0] s1_q;
  logic [10:0] s2_q;
  tsdc_pin_t p;
  tsdc_pin_t prv_q;
  logic [19:0] tc_q;
  logic tick_q;
  tsdc_cfg_t cfg_q;
  tsdc_st_t st_q;
  tsdc_st_t st_d;
  logic [12:0] tmr_q;
  logic [12:0] tmr_d;
  logic tgt_q;
  logic tgt_d;
  logic used_q;
  logic used_d;
  logic elev_d;
  logic [12:0] elev_tk;
  logic [12:0] pause_tk;
  logic neutral;
  logic ovr_p;
  logic go_x;
  logic go_r;
  logic avail_t;
  logic avail_o;
  logic [6:0] thold_q;
  logic [5:0] fl_q;
  logic [2:0] ph_q;
  logic blink_q;
  logic t_start;
  logic t_stop;
  logic [6:0] sx_q;
  logic [7:0] win_q;
  logic sx_long;
  logic sx_short;

  // Delay tables in ticks
  function automatic logic [12:0] np_tk(input logic [2:0] s);
    unique case (s)
      3'h0: np_tk = 13'h0;
      3'h1: np_tk = 13'(`TSDC_MS2TK(`TSDC_NP_MS1));
      3'h2: np_tk = 13'(`TSDC_MS2TK(`TSDC_NP_MS2));
      3'h3: np_tk = 13'(`TSDC_MS2TK(`TSDC_NP_MS3));
      3'h4: np_tk = 13'(`TSDC_MS2TK(`TSDC_NP_MS4));
      3'h5: np_tk = 13'(`TSDC_MS2TK(`TSDC_NP_MS5));
      3'h6: np_tk = 13'(`TSDC_MS2TK(`TSDC_NP_MS6));
      3'h7: np_tk = 13'(`TSDC_MS2TK(`TSDC_NP_MS7));
    endcase
  endfunction

  function automatic logic [12:0] el_tk(input logic [2:0] s);
    unique case (s)
      3'h0: el_tk = 13'h0;
      3'h1: el_tk = 13'(`TSDC_MS2TK(`TSDC_EL_MS1));
      3'h2: el_tk = 13'(`TSDC_MS2TK(`TSDC_EL_MS2));
      3'h3: el_tk = 13'(`TSDC_MS2TK(`TSDC_EL_MS3));
      3'h4: el_tk = 13'(`TSDC_MS2TK(`TSDC_EL_MS4));
      3'h5: el_tk = 13'(`TSDC_MS2TK(`TSDC_EL_MS5));
      3'h6: el_tk = 13'(`TSDC_MS2TK(`TSDC_EL_MS6));
      3'h7: el_tk = 13'(`TSDC_MS2TK(`TSDC_EL_MS7));
    endcase
  endfunction

  // Two-flop synchronisers; only the second stage is read
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      s1_q <= `TSDC_PIN_RST;
      s2_q <= `TSDC_PIN_RST;
      prv_q <= tsdc_pin_t'(`TSDC_PIN_RST);
    end else begin
      s1_q <= pins;
      s2_q <= s1_q;
      prv_q <= p;
    end
  end

  assign p = tsdc_pin_t'(s2_q);
  assign neutral = !p.at_norm && !p.at_emer;
  assign ovr_p = (p.ovr_btn && !prv_q.ovr_btn) || (!p.ovr_in_n && prv_q.ovr_in_n);

  // Common time base tick [R24]
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      tc_q <= 20'h0;
      tick_q <= 1'b0;
    end else if (tc_q == 20'(TICK_CYCLES - 1)) begin
      tc_q <= 20'h0;
      tick_q <= 1'b1;
    end else begin
      tc_q <= tc_q + 20'h1;
      tick_q <= 1'b0;
    end
  end

  // Configuration register; all delays off after reset [R2] [R11] [R15]
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      cfg_q <= tsdc_cfg_t'(`TSDC_CFG_RST);
    end else if (reg_wr && reg_addr == `TSDC_CFG_OFF) begin
      cfg_q.pause_sel <= reg_wdata[`TSDC_PAUSE_LSB +: 3];
      cfg_q.elev_sel <= reg_wdata[`TSDC_ELEV_LSB +: 3];
      cfg_q.post_hold <= reg_wdata[`TSDC_POST_BIT];
      cfg_q.test_load <= reg_wdata[`TSDC_LOAD_BIT];
      cfg_q.ext_ex_on <= reg_wdata[`TSDC_EXT_BIT];
    end
  end

  // Read data stands one cycle; unmapped addresses read zero
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      reg_rdata <= 32'h0;
    end else if (reg_rd && reg_addr == `TSDC_CFG_OFF) begin
      reg_rdata <= {23'h0, cfg_q};
    end else if (reg_rd && reg_addr == `TSDC_STAT_OFF) begin
      reg_rdata <= {22'h0, conn_flash, ex_active, ex_sched, test_active,
                    elev_out, tgt_q, 1'b0, 3'(st_q)};
    end else begin
      reg_rdata <= 32'h0;
    end
  end

  assign elev_tk = el_tk(cfg_q.elev_sel);
  assign pause_tk = np_tk(cfg_q.pause_sel);
  // Override lifts an inhibit for the request it arrives with [R19]
  assign go_x = xfer_req && p.at_norm && (!p.xfer_inh || ovr_p);
  assign go_r = rexfer_req && p.at_emer && (!p.rexfer_inh || ovr_p);
  assign avail_t = tgt_q ? p.emer_ok : p.norm_ok;
  assign avail_o = tgt_q ? p.norm_ok : p.emer_ok;

  // Sequencer; override never touches a running timer here [R13]
  always_comb begin
    st_d = st_q;
    tmr_d = tmr_q;
    tgt_d = tgt_q;
    used_d = used_q;
    unique case (st_q)
      S_IDLE: begin
        used_d = 1'b0;
        if (go_x || go_r) begin
          tgt_d = go_x;
          // Warning only between two live sources [R6] [R7] [R8]
          if (p.norm_ok && p.emer_ok && elev_tk != 13'h0) begin
            st_d = S_ELEV;
            tmr_d = elev_tk;
            used_d = 1'b1;
          end else begin
            st_d = S_OPEN;
          end
        end
      end
      S_ELEV: begin
        // Inhibits are not looked at once the delay runs [R9] [R12]
        if (tmr_q == 13'h0) begin
          st_d = S_OPEN;
        end else if (tick_q) begin
          tmr_d = tmr_q - 13'h1;
        end
      end
      S_OPEN: begin
        // Timer loads only once neutral is sensed [R3] [R4]
        if (neutral) begin
          st_d = S_PAUSE;
          tmr_d = pause_tk;
        end
      end
      S_PAUSE: begin
        // Zero setting passes straight through [R1]
        // A failing source does not stop the count [R5]
        if (tmr_q != 13'h0) begin
          if (tick_q) begin
            tmr_d = tmr_q - 13'h1;
          end
        end else if (avail_t || avail_o) begin
          st_d = S_CLOSE;
          tgt_d = avail_t ? tgt_q : !tgt_q;
        end
      end
      S_CLOSE: begin
        if (tgt_q ? p.at_emer : p.at_norm) begin
          // Second elevator run after the switch lands [R14]
          if (cfg_q.post_hold && used_q) begin
            st_d = S_POST;
            tmr_d = elev_tk;
          end else begin
            st_d = S_IDLE;
          end
        end
      end
      S_POST: begin
        if (tmr_q == 13'h0) begin
          st_d = S_IDLE;
        end else if (tick_q) begin
          tmr_d = tmr_q - 13'h1;
        end
      end
      default: begin
        st_d = S_IDLE;
        tmr_d = 13'h0;
      end
    endcase
  end

  // Output held through the transfer only in post hold mode [R10] [R14]
  assign elev_d = st_d == S_ELEV || st_d == S_POST ||
                  (cfg_q.post_hold && used_d &&
                   (st_d == S_OPEN || st_d == S_PAUSE || st_d == S_CLOSE));
  // Sequencer state and switch commands
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      st_q <= S_IDLE;
      tmr_q <= 13'h0;
      tgt_q <= 1'b0;
      used_q <= 1'b0;
      cmd_open <= 1'b0;
      cmd_norm <= 1'b0;
      cmd_emer <= 1'b0;
      elev_out <= 1'b0;
    end else begin
      st_q <= st_d;
      tmr_q <= tmr_d;
      tgt_q <= tgt_d;
      used_q <= used_d;
      cmd_open <= st_d == S_OPEN;
      cmd_norm <= st_d == S_CLOSE && !tgt_d;
      cmd_emer <= st_d == S_CLOSE && tgt_d;
      elev_out <= elev_d;
    end
  end

  // Override events for the external delays, and LED flash latch
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      ovr_pulse <= 1'b0;
      conn_flash <= 1'b0;
    end else begin
      ovr_pulse <= ovr_p; // [R18]
      conn_flash <= conn_fault || (conn_flash && !ovr_p); // [R20]
    end
  end

  // Test start needs a held press or a remote start; a fresh press ends it [R16] [R17]
  assign t_start = !test_active && p.norm_ok &&
                   ((p.test_btn && tick_q &&
                     thold_q == 7'(`TSDC_MS2TK(`TSDC_TEST_HOLD_MS) - 1)) ||
                    (!p.rtest_n && prv_q.rtest_n));
  assign t_stop = test_active && ((p.test_btn && !prv_q.test_btn) ||
                                  (p.rtest_n && !prv_q.rtest_n));

  // Test state and hold counter
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      test_active <= 1'b0;
      thold_q <= 7'h0;
    end else begin
      if (t_start) begin
        test_active <= 1'b1;
      end else if (t_stop) begin
        test_active <= 1'b0;
      end
      if (!p.test_btn || test_active) begin
        thold_q <= 7'h0;
      end else if (tick_q && thold_q != 7'(`TSDC_MS2TK(`TSDC_TEST_HOLD_MS))) begin
        thold_q <= thold_q + 7'h1;
      end
    end
  end

  // Acknowledge flashing, then the LED follows the test state [R23]
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      fl_q <= 6'h0;
      ph_q <= 3'h0;
      blink_q <= 1'b0;
      test_led <= 1'b0;
    end else begin
      if (t_start || t_stop) begin
        fl_q <= 6'(`TSDC_MS2TK(`TSDC_FLASH_MS));
        ph_q <= 3'h0;
        blink_q <= 1'b1;
      end else if (tick_q && fl_q != 6'h0) begin
        fl_q <= fl_q - 6'h1;
        if (ph_q == 3'(`TSDC_MS2TK(`TSDC_BLINK_MS) - 1)) begin
          ph_q <= 3'h0;
          blink_q <= !blink_q;
        end else begin
          ph_q <= ph_q + 3'h1;
        end
      end
      test_led <= (fl_q != 6'h0) ? blink_q : test_active;
    end
  end

  // Button works only with the external exerciser off [R21]
  assign sx_long = !cfg_q.ext_ex_on && p.setex_btn && tick_q &&
                   sx_q == 7'(`TSDC_MS2TK(`TSDC_SX_HOLD_MS) - 1);
  assign sx_short = !cfg_q.ext_ex_on && !p.setex_btn && prv_q.setex_btn &&
                    sx_q != 7'(`TSDC_MS2TK(`TSDC_SX_HOLD_MS)) &&
                    win_q != 8'h0 && ex_sched;

  // Exercise schedule; a start in the same cycle beats override [R22]
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      sx_q <= 7'h0;
      win_q <= 8'h0;
      ex_sched <= 1'b0;
      ex_active <= 1'b0;
    end else begin
      if (!p.setex_btn) begin
        sx_q <= 7'h0;
      end else if (tick_q && sx_q != 7'(`TSDC_MS2TK(`TSDC_SX_HOLD_MS))) begin
        sx_q <= sx_q + 7'h1;
      end
      if (sx_long && ex_sched) begin
        ex_sched <= 1'b0;
        ex_active <= 1'b0;
        win_q <= 8'h0;
      end else if (sx_long) begin
        ex_sched <= 1'b1;
        win_q <= 8'(`TSDC_MS2TK(`TSDC_SX_WIN_MS));
      end else begin
        if (tick_q && win_q != 8'h0) begin
          win_q <= win_q - 8'h1;
        end
        if (sx_short) begin
          ex_active <= 1'b1;
        end else if (ovr_p) begin
          ex_active <= 1'b0; // [R20]
        end
      end
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);
  idle_elev_off_a: assert property ( // [R10]
    st_q == S_IDLE |-> !elev_out) else $error("elevator output on while idle");
  elev_pre_on_a: assert property ( // [R7]
    st_q == S_ELEV |-> elev_out && !cmd_norm && !cmd_emer)
    else $error("elevator delay without elevator output");
  fail_skip_a: assert property ( // [R6]
    $rose(st_q == S_ELEV) |-> $past(p.norm_ok && p.emer_ok))
    else $error("elevator delay on a failed source");
  pause_neutral_a: assert property ( // [R3]
    $rose(st_q == S_PAUSE) |-> $past(neutral) && !cmd_open)
    else $error("pause started away from neutral");
  close_sep_a: assert property ( // [R4]
    $rose(cmd_norm || cmd_emer) |-> $past(st_q == S_PAUSE && tmr_q == 13'h0))
    else $error("close commanded before pause ended");
  pause_run_a: assert property ( // [R5]
    st_q == S_PAUSE && tmr_q != 13'h0 |=> st_q == S_PAUSE)
    else $error("pause cut short");
  pick_live_a: assert property ( // [R5]
    $rose(st_q == S_CLOSE) |-> (tgt_q ? $past(p.emer_ok) : $past(p.norm_ok)))
    else $error("closing onto a dead source");
  elev_inh_a: assert property ( // [R12]
    st_q == S_ELEV && tmr_q != 13'h0 |=> st_q == S_ELEV)
    else $error("elevator delay ended early");
  ovr_clear_a: assert property ( // [R20]
    ovr_p && !conn_fault && !sx_short && !sx_long |=> !conn_flash && !ex_active)
    else $error("override left flash or exercise on");
  test_ack_a: assert property ( // [R23]
    $rose(test_active) |-> fl_q == 6'(`TSDC_MS2TK(`TSDC_FLASH_MS)))
    else $error("test start not acknowledged");
  post_seen_c: cover property (st_q == S_POST);
  test_seen_c: cover property ($rose(test_active));
  pause_fail_c: cover property (st_q == S_PAUSE && tmr_q != 13'h0 && !p.norm_ok);
endmodule

// >>> shared/tsdc_defines.svh
// Constants for the transfer sequence delay control block.
// Assumes a 20 MHz ref_clk; all delays count a common 50 ms tick.
//
// Summary of operation
// (R1) Pause in neutral on every transfer
// (R2) Neutral pause choices 0 to 10 s
// (R3) Pause timer starts only in neutral
// (R4) Confirm separation before closing to second source
// (R5) Failure during pause: finish, pick live source
// (R6) No elevator delay on real source failure
// (R7) Live-to-live transfer: elevator output, then delay
// (R8) Test or exercise: elevator after transfer delays
// (R9) Elevator expiry issues pending transfer command
// (R10) Elevator output off when timer idle
// (R11) Elevator delay choices 0 to 300 s
// (R12) Inhibits never stop running elevator delay
// (R13) Override ignores pause and elevator timers
// (R14) Post hold: keep output, rerun after transfer
// (R15) Post hold configurable, off after reset
// (R16) Two second hold or remote starts test
// (R17) Press or remote release ends test
// (R18) Override ends start and transfer delays
// (R19) Override bypasses transfer and retransfer inhibits
// (R20) Override stops LED flashing, cancels exercise
// (R21) Set Exercise only with external exerciser off
// (R22) Five second hold schedules, press starts exercise
// (R23) Test LED flashes twice per second, two seconds
// (R24) Timers count common tick, idle after reset
`ifndef TSDC_DEFINES_SVH
`define TSDC_DEFINES_SVH
`define TSDC_CLK_NS 50
`define TSDC_TICK_US 50000
`define TSDC_TICK_CYC (`TSDC_TICK_US * 1000 / `TSDC_CLK_NS)
`define TSDC_MS2TK(ms) ((ms) * 1000 / `TSDC_TICK_US)
`define TSDC_NP_MS1 500
`define TSDC_NP_MS2 1000
`define TSDC_NP_MS3 2000
`define TSDC_NP_MS4 3000
`define TSDC_NP_MS5 4000
`define TSDC_NP_MS6 6000
`define TSDC_NP_MS7 10000
`define TSDC_EL_MS1 1000
`define TSDC_EL_MS2 2000
`define TSDC_EL_MS3 3000
`define TSDC_EL_MS4 5000
`define TSDC_EL_MS5 30000
`define TSDC_EL_MS6 120000
`define TSDC_EL_MS7 300000
`define TSDC_TEST_HOLD_MS 2000
`define TSDC_FLASH_MS 2000
`define TSDC_BLINK_MS 250
`define TSDC_SX_HOLD_MS 5000
`define TSDC_SX_WIN_MS 10000
`define TSDC_CFG_OFF 8'h00
`define TSDC_STAT_OFF 8'h04
`define TSDC_PAUSE_LSB 0
`define TSDC_ELEV_LSB 3
`define TSDC_POST_BIT 6
`define TSDC_LOAD_BIT 7
`define TSDC_EXT_BIT 8
`define TSDC_CFG_RST 9'h000
`define TSDC_PIN_RST 11'h018
`endif

// >>> shared/tsdc_pkg.sv
// Types shared by the transfer sequence delay control block.
// Assumes the defines header supplies all numeric constants.
package tsdc_pkg;
  // Sequencer states
  typedef enum logic [2:0] {
    S_IDLE, S_ELEV, S_OPEN, S_PAUSE, S_CLOSE, S_POST
  } tsdc_st_t;
  // Software configuration word
  typedef struct packed {
    logic ext_ex_on;
    logic test_load;
    logic post_hold;
    logic [2:0] elev_sel;
    logic [2:0] pause_sel;
  } tsdc_cfg_t;
  // Panel, sensing and field inputs, all asynchronous
  typedef struct packed {
    logic norm_ok;
    logic emer_ok;
    logic at_norm;
    logic at_emer;
    logic test_btn;
    logic ovr_btn;
    logic ovr_in_n;
    logic rtest_n;
    logic setex_btn;
    logic xfer_inh;
    logic rexfer_inh;
  } tsdc_pin_t;
endpackage

// >>> sim/tsdc_switch_model.sv
// Switch mechanism model: follows open and close commands after a travel time.
// Assumes the sequencer drives registered command levels on ref_clk.
`timescale 1ns/1ps
module tsdc_switch_model (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic slow,
  input wire logic cmd_open,
  input wire logic cmd_norm,
  input wire logic cmd_emer,
  output logic at_norm,
  output logic at_emer
);
  logic [3:0] travel_q;
  logic moving;
  // Only a command that changes the contacts starts the actuator
  assign moving = (cmd_open && (at_norm || at_emer)) || (cmd_norm && !at_norm) ||
                  (cmd_emer && !at_emer);
  // Travel timer; slow mode mimics a sluggish actuator
  always_ff @(posedge ref_clk) begin
    if (!reset_n || !moving) begin
      travel_q <= 4'h0;
    end else begin
      travel_q <= travel_q + 4'h1;
    end
  end
  // Contacts power up closed on normal; no interlock, so a bad command shows
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      at_norm <= 1'h1;
      at_emer <= 1'h0;
    end else if (moving && travel_q == (slow ? 4'hC : 4'h3)) begin
      at_norm <= cmd_norm;
      at_emer <= cmd_emer;
    end
  end
endmodule

// >>> sim/tsdc_top_test.sv
// Self-checking bench for the transfer sequencer, register port and panel.
// Assumes a 4-cycle tick so that every delay stays short.
`timescale 1ns/1ps
`include "tsdc_defines.svh"
module tsdc_top_test;
  import tsdc_pkg::*;
  logic ref_clk = 1'h0;
  logic reset_n = 1'h0;
  tsdc_pin_t pin_b;
  tsdc_pin_t dut_pins;
  logic xfer_req = 1'h0;
  logic rexfer_req = 1'h0;
  logic conn_fault = 1'h0;
  logic reg_wr = 1'h0;
  logic reg_rd = 1'h0;
  logic slow = 1'h0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] reg_rdata;
  logic [31:0] rd_v;
  logic cmd_open, cmd_norm, cmd_emer, elev_out, ovr_pulse, test_active, test_led;
  logic ex_sched, ex_active, conn_flash, at_norm, at_emer, led_prev;
  int n_fail = 0;
  int check_count = 0;
  int n_ovr = 0;
  int n;
  int k;

  always #25 ref_clk = ~ref_clk;

  // Switch sensing comes from the mechanism model, the rest from the bench
  always_comb begin
    dut_pins = pin_b;
    dut_pins.at_norm = at_norm;
    dut_pins.at_emer = at_emer;
  end

  // Override pulses seen; sampled mid-cycle so the count never races a check
  always @(negedge ref_clk) begin
    if (ovr_pulse === 1'h1) begin
      n_ovr++;
    end
  end

  tsdc_top #(.TICK_CYCLES(4)) i_dut (
    .ref_clk(ref_clk), .reset_n(reset_n), .pins(dut_pins), .xfer_req(xfer_req),
    .rexfer_req(rexfer_req), .conn_fault(conn_fault), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .cmd_open(cmd_open), .cmd_norm(cmd_norm), .cmd_emer(cmd_emer), .elev_out(elev_out),
    .ovr_pulse(ovr_pulse), .test_active(test_active), .test_led(test_led),
    .ex_sched(ex_sched), .ex_active(ex_active), .conn_flash(conn_flash)
  );

  tsdc_switch_model i_sw (
    .ref_clk(ref_clk), .reset_n(reset_n), .slow(slow), .cmd_open(cmd_open),
    .cmd_norm(cmd_norm), .cmd_emer(cmd_emer), .at_norm(at_norm), .at_emer(at_emer)
  );

  function automatic logic sel(input int idx);
    case (idx)
      0: return cmd_open;
      1: return cmd_norm;
      2: return cmd_emer;
      3: return elev_out;
      4: return test_active;
      5: return ex_sched;
      default: return ex_active;
    endcase
  endfunction

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic cyc(input int c);
    repeat (c) @(posedge ref_clk);
  endtask

  // Counts cycles until the chosen output reaches v; returns lim on timeout
  task automatic wait_sig(input int idx, input logic v, input int lim, output int cnt);
    cnt = 0;
    while (cnt < lim) begin
      @(posedge ref_clk);
      #1;
      if (sel(idx) === v) begin
        break;
      end
      cnt++;
    end
    @(posedge ref_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge ref_clk);
    reg_wr <= 1'h0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge ref_clk);
    reg_rd <= 1'h0;
    #1 d = reg_rdata;
    @(posedge ref_clk);
  endtask

  // Counts test indicator changes over len cycles
  task automatic led_toggles(input int len, output int t);
    t = 0;
    led_prev = test_led;
    repeat (len) begin
      @(posedge ref_clk);
      #1;
      if (test_led !== led_prev) begin
        t++;
      end
      led_prev = test_led;
    end
    @(posedge ref_clk);
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Hang guard, well beyond the few thousand cycles the sequence needs
  initial begin
    repeat (30000) @(posedge ref_clk);
    n_fail++;
    $display("MISMATCH watchdog expected done seen timeout");
    test_done();
  end

  initial begin
    pin_b = '{norm_ok: 1'h1, emer_ok: 1'h1, ovr_in_n: 1'h1, rtest_n: 1'h1, default: 1'h0};
    cyc(5);
    reset_n <= 1'h1;
    cyc(3);
    chk("outs", 0, {cmd_open, cmd_norm, cmd_emer, elev_out, test_led, conn_flash});
    rd(`TSDC_CFG_OFF, rd_v); chk("cfg_rst", 0, rd_v);
    rd(`TSDC_STAT_OFF, rd_v); chk("stat_rst", 0, rd_v);
    wr(8'h10, 32'h1FF);
    rd(8'h10, rd_v); chk("unmapped", 0, rd_v);
    rd(`TSDC_CFG_OFF, rd_v); chk("cfg_kept", 0, rd_v);
    // Transfer to emergency with a half second neutral pause
    wr(`TSDC_CFG_OFF, 32'h001);
    xfer_req <= 1'h1;
    wait_sig(0, 1'h1, 10, n); chk("open_lat", 1, n < 4);
    xfer_req <= 1'h0;
    wait_sig(0, 1'h0, 40, n);
    wait_sig(2, 1'h1, 80, n); chk("pause_len", 1, n >= 32 && n <= 44);
    chk("separated", 0, at_norm);
    wait_sig(2, 1'h0, 40, n);
    // Retransfer whose target dies during the pause
    rexfer_req <= 1'h1;
    wait_sig(0, 1'h1, 10, n);
    rexfer_req <= 1'h0;
    wait_sig(0, 1'h0, 40, n);
    pin_b.norm_ok <= 1'h0;
    wait_sig(2, 1'h1, 80, n); chk("fail_len", 1, n >= 32 && n <= 44);
    chk("fail_norm", 0, cmd_norm);
    wait_sig(2, 1'h0, 40, n);
    // Live-to-live retransfer with a one second elevator delay, slow actuator
    pin_b.norm_ok <= 1'h1;
    slow <= 1'h1;
    cyc(2); // Restored source must pass the synchroniser before the request
    wr(`TSDC_CFG_OFF, 32'h008);
    rexfer_req <= 1'h1;
    wait_sig(3, 1'h1, 10, n); chk("elev_on", 1, n < 4 && cmd_open === 1'h0);
    rd(`TSDC_STAT_OFF, rd_v); chk("stat_elev", 32'h021, rd_v);
    rexfer_req <= 1'h0;
    pin_b.rexfer_inh <= 1'h1;
    pin_b.ovr_btn <= 1'h1;
    wait_sig(0, 1'h1, 120, n); chk("elev_len", 1, n >= 68 && n <= 84);
    chk("elev_off", 0, elev_out);
    pin_b.rexfer_inh <= 1'h0;
    pin_b.ovr_btn <= 1'h0;
    wait_sig(1, 1'h1, 80, n);
    wait_sig(1, 1'h0, 40, n);
    // Real failure under inhibit: no elevator, override forces the transfer
    slow <= 1'h0;
    pin_b.norm_ok <= 1'h0;
    pin_b.xfer_inh <= 1'h1;
    cyc(3); // Inhibit and failure must be seen before the request
    xfer_req <= 1'h1;
    wait_sig(0, 1'h1, 20, n); chk("inhibited", 20, n);
    pin_b.ovr_in_n <= 1'h0;
    wait_sig(0, 1'h1, 10, n); chk("ovr_xfer", 1, n < 10);
    chk("no_elev", 0, elev_out);
    xfer_req <= 1'h0;
    pin_b.ovr_in_n <= 1'h1;
    pin_b.xfer_inh <= 1'h0;
    wait_sig(2, 1'h1, 60, n);
    wait_sig(2, 1'h0, 40, n);
    // Post-transfer hold keeps the elevator output through a second run
    pin_b.norm_ok <= 1'h1;
    wr(`TSDC_CFG_OFF, 32'h0C8);
    rd(`TSDC_CFG_OFF, rd_v); chk("cfg_post", 32'h0C8, rd_v);
    rexfer_req <= 1'h1;
    wait_sig(3, 1'h1, 10, n);
    rexfer_req <= 1'h0;
    wait_sig(0, 1'h1, 120, n); chk("post_kept", 1, elev_out);
    wait_sig(1, 1'h1, 60, n);
    wait_sig(1, 1'h0, 40, n);
    wait_sig(3, 1'h0, 120, n); chk("post_len", 1, n >= 64 && n <= 84);
    wr(`TSDC_CFG_OFF, 32'h000);
    // Test button: short hold ignored, long hold starts, press ends
    pin_b.test_btn <= 1'h1;
    cyc(80);
    pin_b.test_btn <= 1'h0;
    cyc(10); chk("short_hold", 0, test_active);
    pin_b.test_btn <= 1'h1;
    wait_sig(4, 1'h1, 200, n); chk("hold_len", 1, n >= 150 && n <= 170);
    pin_b.test_btn <= 1'h0;
    led_toggles(158, k); chk("start_flash", 1, k >= 6 && k <= 9);
    cyc(20); chk("led_on", 1, test_led);
    pin_b.test_btn <= 1'h1;
    cyc(2);
    pin_b.test_btn <= 1'h0;
    wait_sig(4, 1'h0, 10, n); chk("stop_btn", 1, n < 10);
    led_toggles(158, k); chk("stop_flash", 1, k >= 6 && k <= 9);
    cyc(20); chk("led_off", 0, test_led);
    pin_b.rtest_n <= 1'h0;
    wait_sig(4, 1'h1, 10, n); chk("remote_on", 1, n < 10);
    pin_b.rtest_n <= 1'h1;
    wait_sig(4, 1'h0, 10, n); chk("remote_off", 1, n < 10);
    cyc(200);
    // Exercise button, refused while the external exerciser is on
    wr(`TSDC_CFG_OFF, 32'h100);
    pin_b.setex_btn <= 1'h1;
    cyc(420);
    pin_b.setex_btn <= 1'h0;
    cyc(5); chk("ext_ignore", 0, ex_sched);
    wr(`TSDC_CFG_OFF, 32'h000);
    pin_b.setex_btn <= 1'h1;
    wait_sig(5, 1'h1, 430, n); chk("sched_len", 1, n >= 390 && n <= 410);
    pin_b.setex_btn <= 1'h0;
    cyc(10);
    pin_b.setex_btn <= 1'h1;
    cyc(4);
    pin_b.setex_btn <= 1'h0;
    wait_sig(6, 1'h1, 10, n); chk("ex_now", 1, n < 10);
    conn_fault <= 1'h1;
    @(posedge ref_clk);
    conn_fault <= 1'h0;
    cyc(2); chk("flash_set", 1, conn_flash);
    k = n_ovr;
    pin_b.ovr_btn <= 1'h1;
    wait_sig(6, 1'h0, 10, n); chk("ex_cancel", 1, n < 10);
    chk("flash_stop", 0, conn_flash);
    chk("ovr_once", 1, n_ovr - k);
    pin_b.ovr_btn <= 1'h0;
    pin_b.setex_btn <= 1'h1;
    wait_sig(5, 1'h0, 430, n); chk("unsched", 1, n < 430);
    pin_b.setex_btn <= 1'h0;
    cyc(5);
    test_done();
  end
endmodule
